// >>> verilog/acb_pkg.sv
// shared constants and types of the converter configuration register bank
package acb_pkg;

  localparam int ADDR_W = 13;

  // register offsets on the serial control port
  localparam logic [12:0] A_IDX_A   = 13'h004;
  localparam logic [12:0] A_IDX_B   = 13'h005;
  localparam logic [12:0] A_PMODE   = 13'h008;
  localparam logic [12:0] A_ENH     = 13'h00C;
  localparam logic [12:0] A_OUTMODE = 13'h014;
  localparam logic [12:0] A_P1_LO   = 13'h019;
  localparam logic [12:0] A_P1_HI   = 13'h01A;
  localparam logic [12:0] A_P2_LO   = 13'h01B;
  localparam logic [12:0] A_P2_HI   = 13'h01C;
  localparam logic [12:0] A_SERIAL  = 13'h021;
  localparam logic [12:0] A_CHSTAT  = 13'h022;
  localparam logic [12:0] A_XFER    = 13'h0FF;
  localparam logic [12:0] A_OVR     = 13'h100;
  localparam logic [12:0] A_IO2     = 13'h101;
  localparam logic [12:0] A_IO3     = 13'h102;
  localparam logic [12:0] A_SYNC    = 13'h109;

  // values after power-on reset
  localparam logic [7:0] RST_IDX_A   = 8'h0F;
  localparam logic [7:0] RST_IDX_B   = 8'h3F;
  localparam logic [7:0] RST_OUTMODE = 8'h01;
  localparam logic [7:0] RST_SERIAL  = 8'h41;
  localparam logic [7:0] RST_ZERO    = 8'h00;

  // writable bits; open bits read as zero
  localparam logic [7:0] M_OUTMODE = 8'h45;
  localparam logic [7:0] M_SERIAL  = 8'hFB;
  localparam logic [7:0] M_OVR     = 8'h77;
  localparam logic [7:0] M_IO2     = 8'h01;
  localparam logic [7:0] M_IO3     = 8'h08;
  localparam logic [7:0] M_SYNC    = 8'h03;

  // field positions
  localparam int PM_PIN_FN  = 5;
  localparam int CHOP_BIT   = 2;
  localparam int XFER_BIT   = 0;
  localparam int ST_PD      = 0;
  localparam int ST_ORST    = 1;
  localparam int OVR_EN     = 6;
  localparam int IO3_CMG_PD = 3;
  localparam int DATA_IDX_W = 4;

  // sample-rate override codes and their rates in MSPS
  localparam logic [2:0] RATE_20 = 3'h0;
  localparam logic [2:0] RATE_40 = 3'h1;
  localparam logic [2:0] RATE_50 = 3'h2;
  localparam logic [2:0] RATE_65 = 3'h3;
  localparam logic [6:0] MSPS_20 = 7'h14;
  localparam logic [6:0] MSPS_40 = 7'h28;
  localparam logic [6:0] MSPS_50 = 7'h32;
  localparam logic [6:0] MSPS_65 = 7'h41;

  typedef enum logic [1:0] {
    PM_NORMAL, PM_POWERDOWN, PM_STANDBY, PM_DIGRESET
  } acb_pmode_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [12:0] addr;
    logic [7:0]  wdata;
  } acb_req_t;

  typedef struct packed {
    logic dpClkEn;
    logic dpReset;
    logic outEn;
    logic standby;
    logic powerDown;
    logic chopEn;
  } acb_pwr_t;

  typedef struct packed {
    logic       ovrEn;
    logic [1:0] res;
    logic [2:0] rate;
  } acb_ovr_t;

  localparam acb_pwr_t PWR_RST = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

endpackage

// >>> verilog/acb_config_regs.sv
// configuration register bank of the octal serial-output converter
`timescale 1ns/10ps
// Behaviour
// - writes take effect at once, except override
// - override loads only on transfer bit 0
// - pin with function bit set: standby
// - pin with function bit clear: full power-down
// - mode 00 keeps all channels running
// - mode 01 stops clocks, resets path, outputs off
// - mode 10 stops clocks, outputs off, no reset
// - mode 11 resets path clocks and outputs
// - control port reset only by power-on reset
// - enhancement bit 2 enables first-stage chopping
// - index low nibbles select target data channels
// - second index also selects output clock channels
// - global settings ignore channel selection
// - status bit0 powers down, bit1 resets output
// - rate codes map to 20/40/50/65 MSPS
// - upgrade attempt powers the whole chip down
module acb_config_regs #(
  parameter int         NUM_CH     = 8,
  parameter logic [2:0] GRADE_RATE = acb_pkg::RATE_65
) (
  // clock and power-on reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // register port from the serial control engine
  input  wire acb_pkg::acb_req_t req,
  output logic [7:0]             rdData,
  output logic                   rdValid,
  // external power-down pin
  input  wire logic              externalPowerdownPin,
  // power and conversion controls
  output acb_pkg::acb_pwr_t      pwr,
  output acb_pkg::acb_ovr_t      ovrActive,
  output logic [6:0]             rateMsps,
  // per-channel controls
  output logic [NUM_CH-1:0]      chPowerDown,
  output logic [NUM_CH-1:0]      chOutReset,
  output logic [1:0]             clkOutReset,
  // global settings
  output logic [15:0]            pattern1,
  output logic [15:0]            pattern2,
  output logic [7:0]             outputMode,
  output logic [7:0]             serialCtrl,
  output logic [7:0]             ioCtrl2,
  output logic [7:0]             ioCtrl3,
  output logic [7:0]             syncCtrl,
  output logic                   commonModeGeneratorPd
);
  import acb_pkg::*;
  if (NUM_CH < 1 || NUM_CH > 2 * DATA_IDX_W) begin : g_chk
    $error("NUM_CH must be 1 to 8");
  end
  logic [7:0]  idxA;
  logic [7:0]  idxB;
  logic        pmPinFn;
  acb_pmode_t  pmMode;
  logic        chopReg;
  logic [7:0]  ovrShadow;
  logic        pdMeta;
  logic        pdPinS;
  logic        ovrKill;
  acb_pmode_t  effMode;
  acb_pwr_t    next_pwr;
  logic [7:0]  next_rdData;
  logic [1:0]  statRead;
  logic [NUM_CH-1:0] chSel;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////
  // pin synchroniser
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pdMeta <= 1'b0;
      pdPinS <= 1'b0;
    end else begin
      pdMeta <= externalPowerdownPin;
      pdPinS <= pdMeta;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // channel index registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      idxA <= RST_IDX_A;
      idxB <= RST_IDX_B;
    end else if (req.wr) begin
      if (req.addr == A_IDX_A) begin
        idxA <= req.wdata;
      end
      if (req.addr == A_IDX_B) begin
        idxB <= req.wdata;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // power modes and enhancement control
  // only rst_b clears these; digital reset leaves the port alone
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pmPinFn <= 1'b0;
      pmMode  <= PM_NORMAL;
      chopReg <= 1'b0;
    end else if (req.wr) begin
      if (req.addr == A_PMODE) begin
        pmPinFn <= req.wdata[PM_PIN_FN];
        pmMode  <= acb_pmode_t'(req.wdata[1:0]);
      end
      if (req.addr == A_ENH) begin
        chopReg <= req.wdata[CHOP_BIT];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // global settings, no channel qualification
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pattern1   <= {RST_ZERO, RST_ZERO};
      pattern2   <= {RST_ZERO, RST_ZERO};
      outputMode <= RST_OUTMODE;
      serialCtrl <= RST_SERIAL;
      ioCtrl2    <= RST_ZERO;
      ioCtrl3    <= RST_ZERO;
      syncCtrl   <= RST_ZERO;
    end else if (req.wr) begin
      unique case (req.addr)
        A_P1_LO:   pattern1[7:0]  <= req.wdata;
        A_P1_HI:   pattern1[15:8] <= req.wdata;
        A_P2_LO:   pattern2[7:0]  <= req.wdata;
        A_P2_HI:   pattern2[15:8] <= req.wdata;
        A_OUTMODE: outputMode <= req.wdata & M_OUTMODE;
        A_SERIAL:  serialCtrl <= req.wdata & M_SERIAL;
        A_IO2:     ioCtrl2    <= req.wdata & M_IO2;
        A_IO3:     ioCtrl3    <= req.wdata & M_IO3;
        A_SYNC:    syncCtrl   <= req.wdata & M_SYNC;
        default: ;
      endcase
    end
  end
  assign commonModeGeneratorPd = ioCtrl3[IO3_CMG_PD];
  //////////////////////////////////////////////////////////////////////
  // sample-rate override: shadow, then load on transfer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ovrShadow <= RST_ZERO;
      ovrActive <= '0;
    end else if (req.wr) begin
      if (req.addr == A_OVR) begin
        ovrShadow <= req.wdata & M_OVR;
      end
      if (req.addr == A_XFER && req.wdata[XFER_BIT]) begin
        ovrActive <= '{ovrShadow[OVR_EN], ovrShadow[5:4], ovrShadow[2:0]};
      end
    end
  end
  function automatic logic [6:0] msps(input logic [2:0] code);
    unique case (code)
      RATE_20: msps = MSPS_20;
      RATE_40: msps = MSPS_40;
      RATE_50: msps = MSPS_50;
      RATE_65: msps = MSPS_65;
      default: msps = 7'h00;
    endcase
  endfunction
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rateMsps <= 7'h00;
    end else begin
      rateMsps <= msps(ovrActive.ovrEn ? ovrActive.rate : GRADE_RATE);
    end
  end
  //////////////////////////////////////////////////////////////////////
  // power decode
  // a requested upgrade is never applied; the chip powers down instead
  always_comb begin
    ovrKill = ovrActive.ovrEn && (ovrActive.rate > GRADE_RATE);
    effMode = pmMode;
    if (pdPinS) begin
      effMode = pmPinFn ? PM_STANDBY : PM_POWERDOWN;
    end
    if (ovrKill) begin
      effMode = PM_POWERDOWN;
    end
    next_pwr = PWR_RST;
    next_pwr.chopEn = chopReg;
    unique case (effMode)
      PM_NORMAL: begin
        next_pwr.dpClkEn = 1'b1;
      end
      PM_POWERDOWN: begin
        next_pwr.dpClkEn   = 1'b0;
        next_pwr.dpReset   = 1'b1;
        next_pwr.outEn     = 1'b0;
        next_pwr.powerDown = 1'b1;
      end
      PM_STANDBY: begin
        next_pwr.dpClkEn = 1'b0;
        next_pwr.outEn   = 1'b0;
        next_pwr.standby = 1'b1;
      end
      PM_DIGRESET: begin
        next_pwr.dpClkEn = 1'b0;
        next_pwr.dpReset = 1'b1;
        next_pwr.outEn   = 1'b0;
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr <= PWR_RST;
    end else begin
      pwr <= next_pwr;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // per-channel status, gated by the index selection
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    if (i < DATA_IDX_W) begin : g_a
      assign chSel[i] = idxA[i];
    end else begin : g_b
      assign chSel[i] = idxB[i-DATA_IDX_W];
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        chPowerDown[i] <= 1'b0;
        chOutReset[i]  <= 1'b0;
      end else if (req.wr && req.addr == A_CHSTAT && chSel[i]) begin
        chPowerDown[i] <= req.wdata[ST_PD];
        chOutReset[i]  <= req.wdata[ST_ORST];
      end
    end
  end
  // clock channels take only the output reset bit
  for (genvar j = 0; j < 2; j++) begin : g_clk
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        clkOutReset[j] <= 1'b0;
      end else if (req.wr && req.addr == A_CHSTAT
                   && idxB[DATA_IDX_W+j]) begin
        clkOutReset[j] <= req.wdata[ST_ORST];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // read-back: status shows the lowest selected data channel
  always_comb begin
    statRead = {(|(clkOutReset & idxB[5:4])), 1'b0};
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (chSel[i]) begin
        statRead = {chOutReset[i], chPowerDown[i]};
      end
    end
  end
  always_comb begin
    next_rdData = 8'h00;
    unique case (req.addr)
      A_IDX_A:   next_rdData = idxA;
      A_IDX_B:   next_rdData = idxB;
      A_PMODE:   next_rdData = {2'h0, pmPinFn, 3'h0, pmMode};
      A_ENH:     next_rdData = {5'h00, chopReg, 2'h0};
      A_OUTMODE: next_rdData = outputMode;
      A_P1_LO:   next_rdData = pattern1[7:0];
      A_P1_HI:   next_rdData = pattern1[15:8];
      A_P2_LO:   next_rdData = pattern2[7:0];
      A_P2_HI:   next_rdData = pattern2[15:8];
      A_SERIAL:  next_rdData = serialCtrl;
      A_CHSTAT:  next_rdData = {6'h00, statRead};
      A_OVR:     next_rdData = ovrShadow;
      A_IO2:     next_rdData = ioCtrl2;
      A_IO3:     next_rdData = ioCtrl3;
      A_SYNC:    next_rdData = syncCtrl;
      default:   next_rdData = 8'h00;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData  <= 8'h00;
      rdValid <= 1'b0;
    end else begin
      rdValid <= req.rd;
      if (req.rd) begin
        rdData <= next_rdData;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // checks
  a_mode_write: assert property (
    req.wr && req.addr == A_PMODE && req.wdata[1:0] == 2'h2
    && !pdPinS && !ovrKill ##1 !pdPinS && !ovrKill
    |=> pwr.standby && !pwr.dpReset)
    else $error("power mode write not applied");
  a_xfer_load: assert property (
    $changed(ovrActive)
    |-> $past(req.wr && req.addr == A_XFER && req.wdata[XFER_BIT]))
    else $error("override loaded without transfer");
  a_pin_standby: assert property (
    pdPinS && pmPinFn && !ovrKill
    |=> pwr.standby && !pwr.dpClkEn && !pwr.outEn)
    else $error("pin did not give standby");
  a_pin_pdown: assert property (
    pdPinS && !pmPinFn
    |=> pwr.powerDown && pwr.dpReset && !pwr.outEn)
    else $error("pin did not give power-down");
  a_mode_normal: assert property (
    pmMode == PM_NORMAL && !pdPinS && !ovrKill
    |=> pwr.dpClkEn && pwr.outEn && !pwr.dpReset && !pwr.powerDown)
    else $error("normal mode not active");
  a_mode_pdown: assert property (
    pmMode == PM_POWERDOWN && !pdPinS
    |=> !pwr.dpClkEn && pwr.dpReset && !pwr.outEn)
    else $error("power-down mode wrong");
  a_mode_standby: assert property (
    pmMode == PM_STANDBY && !pdPinS && !ovrKill
    |=> !pwr.dpClkEn && !pwr.dpReset && !pwr.outEn)
    else $error("standby mode wrong");
  a_dig_reset: assert property (
    pmMode == PM_DIGRESET && !pdPinS && !ovrKill
    |=> pwr.dpReset && !pwr.dpClkEn && !pwr.powerDown)
    else $error("digital reset wrong");
  a_port_alive: assert property (
    pwr.dpReset && req.wr && req.addr == A_P1_LO
    |=> pattern1[7:0] == $past(req.wdata))
    else $error("control port blocked in reset");
  a_chop_write: assert property (
    req.wr && req.addr == A_ENH
    |=> ##1 pwr.chopEn == $past(req.wdata[CHOP_BIT], 2))
    else $error("chop enable not applied");
  a_ch_unsel: assert property (
    req.wr && req.addr == A_CHSTAT && !chSel[0]
    |=> $stable(chPowerDown[0]) && $stable(chOutReset[0]))
    else $error("unselected channel changed");
  a_upgrade: assert property (
    ovrKill |=> pwr.powerDown && !pwr.outEn)
    else $error("upgrade not blocked");
endmodule

// >>> sim/acb_host_model.sv
// host model that drives the register port of the bank
`timescale 1ns/10ps
module acb_host_model (
  // clock
  input  wire logic       ref_clk,
  // register port
  output acb_pkg::acb_req_t req,
  input  wire logic [7:0] rdData,
  input  wire logic       rdValid
);
  import acb_pkg::*;
  //////////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
  end

  // one pulse per request, held across the edge that takes it
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    req <= '{1'b1, 1'b0, a, d};
    @(negedge ref_clk);
    req <= '0;
  endtask

  task automatic rd(input logic [12:0] a, output logic [7:0] d,
                    output logic ok);
    @(negedge ref_clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge ref_clk);
    req <= '0;
    ok = rdValid;
    d  = rdData;
  endtask

  // override value only reaches the converter on the transfer write
  task automatic load(input logic [7:0] v);
    wr(A_OVR, v);
    wr(A_XFER, 8'h01);
  endtask

  // re-run initialisation once the sample clock is stable
  task automatic reinit();
    wr(A_PMODE, 8'h03);
    wr(A_PMODE, 8'h00);
  endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench of the configuration register bank
`timescale 1ns/10ps
module tb_top;
  import acb_pkg::*;
  typedef struct packed {
    logic [12:0] a;
    logic [7:0]  w;
    logic [7:0]  e;
  } acb_row_t;
  localparam acb_row_t ROWS [14] = '{
    '{A_OUTMODE, 8'hFF, 8'h45}, '{A_SERIAL, 8'hFF, 8'hFB},
    '{A_IO2, 8'hFF, 8'h01},     '{A_IO3, 8'hFF, 8'h08},
    '{A_SYNC, 8'hFF, 8'h03},    '{A_ENH, 8'h04, 8'h04},
    '{A_P1_LO, 8'hA5, 8'hA5},   '{A_P1_HI, 8'h5A, 8'h5A},
    '{A_P2_LO, 8'h3C, 8'h3C},   '{A_P2_HI, 8'hC3, 8'hC3},
    '{A_CHSTAT, 8'h03, 8'h03},  '{A_OVR, 8'hFF, 8'h77},
    '{13'h003, 8'hFF, 8'h00},   '{A_XFER, 8'h00, 8'h00}};
  localparam logic [6:0] MS [4] = '{MSPS_20, MSPS_40, MSPS_50, MSPS_65};
  localparam logic [4:0] PM [3] = '{5'b10100, 5'b01001, 5'b00010};
  logic        ref_clk;
  logic        rst_b;
  logic        pdPin;
  acb_req_t    req;
  logic [7:0]  rdData;
  logic        rdValid;
  acb_pwr_t    pwr;
  acb_ovr_t    ovrActive;
  logic [6:0]  rateMsps;
  logic [7:0]  chPowerDown;
  logic [7:0]  chOutReset;
  logic [1:0]  clkOutReset;
  logic [15:0] pattern1;
  logic [15:0] pattern2;
  logic [7:0]  outputMode;
  logic [7:0]  serialCtrl;
  logic [7:0]  ioCtrl2;
  logic [7:0]  ioCtrl3;
  logic [7:0]  syncCtrl;
  logic        cmgPd;
  int          mismatches;
  int          checks;
  //////////////////////////////////////////////////////////////////////
  acb_config_regs uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rdData(rdData),
    .rdValid(rdValid), .externalPowerdownPin(pdPin), .pwr(pwr),
    .ovrActive(ovrActive), .rateMsps(rateMsps),
    .chPowerDown(chPowerDown), .chOutReset(chOutReset),
    .clkOutReset(clkOutReset), .pattern1(pattern1),
    .pattern2(pattern2), .outputMode(outputMode),
    .serialCtrl(serialCtrl), .ioCtrl2(ioCtrl2), .ioCtrl3(ioCtrl3),
    .syncCtrl(syncCtrl), .commonModeGeneratorPd(cmgPd));
  acb_host_model host (
    .ref_clk(ref_clk), .req(req), .rdData(rdData), .rdValid(rdValid));
  //////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // read answer is due exactly one cycle after the request
  task automatic rdChk(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host.rd(a, d, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH t=%0t no read answer", $time);
      wrap_up();
    end else begin
      chk(d, e);
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    pdPin = 1'b0;
    mismatches = 0;
    checks = 0;
    idle(10);
    rst_b = 1'b1;
    idle(2);
    chk(pwr, PWR_RST);
    chk(outputMode, 8'h01);
    chk(serialCtrl, 8'h41);
    chk(pattern1, 16'h0000);
    chk(ovrActive, 6'h00);
    chk(rateMsps, MSPS_65);
    chk(chPowerDown, 8'h00);
    rdChk(A_IDX_A, 8'h0F);
    rdChk(A_IDX_B, 8'h3F);
    rdChk(A_CHSTAT, 8'h00);
    rdChk(A_OVR, 8'h00);
    for (int i = 0; i < 14; i++) begin
      host.wr(ROWS[i].a, ROWS[i].w);
      rdChk(ROWS[i].a, ROWS[i].e);
    end
    idle(1);
    chk(pattern1, 16'h5AA5);
    chk(pattern2, 16'hC33C);
    chk(pwr.chopEn, 1'b1);
    chk(ovrActive, 6'h00);
    chk(cmgPd, 1'b1);
    chk(chPowerDown, 8'hFF);
    chk(chOutReset, 8'hFF);
    chk(clkOutReset, 2'b11);
    chk(outputMode, 8'h45);
    chk(serialCtrl, 8'hFB);
    chk(ioCtrl2, 8'h01);
    chk(ioCtrl3, 8'h08);
    chk(syncCtrl, 8'h03);
    // every rate code, then an upgrade that must shut the chip down
    for (int c = 0; c < 4; c++) begin
      host.load(8'h40 | c[7:0]);
      idle(2);
      chk(ovrActive, {3'b100, c[2:0]});
      chk(rateMsps, MS[c]);
    end
    host.load(8'h44);
    idle(2);
    chk(pwr.powerDown, 1'b1);
    host.load(8'h43);
    idle(2);
    chk(pwr.powerDown, 1'b0);
    for (int m = 0; m < 3; m++) begin
      host.wr(A_PMODE, m[7:0]);
      idle(1);
      chk(pwr[5:1], PM[m]);
    end
    host.wr(A_PMODE, 8'h03);
    idle(1);
    chk(pwr.dpReset, 1'b1);
    host.wr(A_P1_LO, 8'h99);
    rdChk(A_P1_LO, 8'h99);
    rdChk(A_P2_LO, 8'h3C);
    host.reinit();
    idle(1);
    chk(pwr[5:1], PM[0]);
    // pin meaning follows the function bit
    host.wr(A_PMODE, 8'h20);
    pdPin = 1'b1;
    idle(4);
    chk(pwr.standby, 1'b1);
    chk(pwr.powerDown, 1'b0);
    host.wr(A_PMODE, 8'h00);
    idle(1);
    chk(pwr.powerDown, 1'b1);
    pdPin = 1'b0;
    idle(4);
    chk(pwr.powerDown, 1'b0);
    // channel selection for local settings
    host.wr(A_IDX_A, 8'h01);
    host.wr(A_IDX_B, 8'h00);
    host.wr(A_CHSTAT, 8'h00);
    idle(1);
    chk(chPowerDown, 8'hFE);
    chk(chOutReset, 8'hFE);
    host.wr(A_IDX_A, 8'h00);
    host.wr(A_IDX_B, 8'h01);
    host.wr(A_CHSTAT, 8'h00);
    idle(1);
    chk(chPowerDown, 8'hEE);
    host.wr(A_IDX_B, 8'h10);
    host.wr(A_CHSTAT, 8'h00);
    idle(1);
    chk(clkOutReset, 2'b10);
    chk(chOutReset, 8'hEE);
    rdChk(A_CHSTAT, 8'h00);
    host.wr(A_P1_HI, 8'h77);
    idle(1);
    chk(pattern1, 16'h7799);
    // a second power-on reset in mid-run
    rst_b = 1'b0;
    idle(2);
    rst_b = 1'b1;
    idle(2);
    chk(pattern1, 16'h0000);
    chk(serialCtrl, 8'h41);
    rdChk(A_SYNC, 8'h00);
    wrap_up();
  end
endmodule
